// ---- verilog/asp_core.sv ----
// Function
// - full duplex serialise and deserialise
// - sixteen entry transmit and receive queues
// - auto cts/rts, rts at trigger level
// - receive threshold flags data ready
// - programmable divisor sets bit period
// - cts change wakes the system
// - receive timeout from 8-bit count
// - programmable gap between transmitted characters
// - break, framing, parity, overflow detection
// - five to eight data bits
// - even, odd, none or stick parity
// - one, one and half, two stops
// - sir zero bit is 3/16 pulse
// - lin master or slave select
// - lin transmit break of programmable length
// - lin receive break detection
// - rs-485 nine bit address/data characters
// - rs-485 rts as direction control
// - seven separately flagged event sources
`timescale 1ns/1ps
`include "asp_defines.svh"
module asp_core (
  input logic clk_in, // 200 MHz clock
  input logic rstn_in, // sync reset, low
  input logic [7:0] addr_in, // register byte address
  input logic [31:0] wr_data_in, // write data
  input logic wr_in, // write strobe
  input logic rd_in, // read strobe
  output logic [31:0] rd_data_out, // read data, next cycle
  input logic rxd_in, // serial receive line
  input logic cts_in, // clear to send, low active
  output logic txd_out, // serial transmit line
  output logic rts_out, // rts / rs-485 direction
  output logic wake_out // cts change wake pulse
);
  import asp_pkg::*;

  asp_state_s st_reg; // all state
  asp_state_s st_next; // next state
  logic tick; // oversample tick
  logic rxline; // decoded receive level
  logic tx_bend; // transmit bit end
  logic rx_bend; // receive sample point
  logic tx_busy; // transmitter has work
  logic tx_bit; // unencoded line bit
  logic tx_push; // queue write
  logic tx_pop; // queue read
  logic rx_push; // queue write
  logic rx_pop; // queue read
  logic [3:0] nb; // data bits per char
  logic [4:0] stop_last; // last tick of the stop, length in ticks less one
  logic [8:0] mask; // data bit mask
  logic [8:0] txw; // head of tx queue
  logic [8:0] rxw; // right aligned rx word
  logic [12:0] ev_set; // flag sets
  logic [12:0] ev_clr; // flag clears
  logic [14:0] l; // line control alias

  // parity bit for a word
  function automatic logic par_f(input logic [8:0] d, input logic [14:0] c);
    if (c[`ASP_L_STICK]) begin
      par_f = ~c[`ASP_L_EVEN];
    end else begin
      par_f = c[`ASP_L_EVEN] ? ^d : ~^d;
    end
  endfunction : par_f

  // derived frame shape
  assign l = st_reg.lcr;
  assign tick = st_reg.bcnt == 16'h0000;
  assign nb = l[`ASP_L_NINE] ? `ASP_NB_NINE : `ASP_NB_MIN + {2'h0, l[`ASP_L_WLEN]};
  assign mask = l[`ASP_L_NINE] ? 9'h1FF : {1'b0, 8'hFF >> (2'h3 - l[`ASP_L_WLEN])};
  assign txw = st_reg.txq[st_reg.tx_rp];
  assign rxw = st_reg.rx_sh >> (4'h9 - nb);
  assign tx_bend = tick && st_reg.tx_sub == `ASP_BIT_LAST;
  assign rx_bend = tick && st_reg.rx_sub == `ASP_OVS_LAST;
  assign tx_busy = st_reg.tx_st != TX_IDLE || st_reg.tx_n != 5'h00;
  // one and a half stops only with a zero length field, which is five bits unless nine-bit words are on
  assign stop_last = !l[`ASP_L_STOP2] ? `ASP_BIT_LAST :
    (l[`ASP_L_WLEN] == 2'h0 ? `ASP_STOP15 : `ASP_STOP2);
  // sir receive: high pulse means zero bit
  assign rxline = l[`ASP_L_IRDA] ? !(rxd_in || st_reg.ir_cnt != 4'h0) : rxd_in;

  // line bit before sir encoding
  always_comb begin
    case (st_reg.tx_st)
      TX_START: tx_bit = 1'b0;
      TX_BRK: tx_bit = 1'b0;
      TX_DATA: tx_bit = st_reg.tx_sh[0];
      TX_PAR: tx_bit = st_reg.tx_par;
      default: tx_bit = 1'b1;
    endcase
  end

  // next state
  always_comb begin
    st_next = st_reg;
    ev_set = '0;
    ev_clr = '0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    st_next.rdata = 32'h0000_0000;
    // divisor counter
    st_next.bcnt = tick ? st_reg.div : st_reg.bcnt - 16'h0001;
    // register writes
    if (wr_in) begin
      case (addr_in)
        `ASP_A_DATA: begin
          if (st_reg.tx_n == `ASP_DEPTH) begin
            ev_set[`ASP_E_TOVF] = 1'b1;
          end else begin
            tx_push = 1'b1;
          end
        end
        `ASP_A_LINE: begin
          st_next.lcr = wr_data_in[`ASP_L_STORE];
          // only a master keeps a break request, so none lingers for later
          if (wr_data_in[`ASP_L_BRK] && wr_data_in[`ASP_L_LIN] && wr_data_in[`ASP_L_LMST]) begin
            st_next.brk_req = 1'b1;
          end
        end
        `ASP_A_FIFO: st_next.fcr = wr_data_in[`ASP_F_STORE];
        `ASP_A_BAUD: st_next.div = wr_data_in[`ASP_B_STORE];
        `ASP_A_TOG: st_next.tog = wr_data_in[`ASP_T_STORE];
        `ASP_A_EVT: ev_clr = wr_data_in[`ASP_EV_STORE];
        default: ;
      endcase
    end
    // register reads, data stand one cycle
    if (rd_in) begin
      case (addr_in)
        `ASP_A_DATA: begin
          if (st_reg.rx_n != 5'h00) begin
            st_next.rdata = {23'h00_0000, st_reg.rxq[st_reg.rx_rp]};
            rx_pop = 1'b1;
          end
        end
        `ASP_A_LINE: st_next.rdata = {17'h0_0000, st_reg.lcr};
        `ASP_A_FIFO: st_next.rdata = {24'h00_0000, st_reg.fcr};
        `ASP_A_BAUD: st_next.rdata = {16'h0000, st_reg.div};
        `ASP_A_TOG: st_next.rdata = {11'h000, st_reg.tog};
        `ASP_A_STAT: st_next.rdata = {20'h0_0000, cts_in, tx_busy, st_reg.tx_n, st_reg.rx_n};
        `ASP_A_EVT: st_next.rdata = {19'h0_0000, st_reg.ev};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
    // transmit queue write
    if (tx_push) begin
      st_next.txq[st_reg.tx_wp] = wr_data_in[`ASP_WORD];
      st_next.tx_wp = st_reg.tx_wp + 4'h1;
    end
    // transmitter
    if (st_reg.tx_st != TX_IDLE && tick) begin
      st_next.tx_sub = st_reg.tx_sub + 5'h01;
    end
    case (st_reg.tx_st)
      TX_IDLE: begin
        st_next.tx_sub = 5'h00;
        st_next.tx_cnt = 8'h00;
        if (st_reg.brk_req && l[`ASP_L_LIN] && l[`ASP_L_LMST]) begin
          st_next.brk_req = 1'b0;
          st_next.tx_st = TX_BRK;
        end else if (st_reg.tx_n != 5'h00 && !(l[`ASP_L_ACTS] && cts_in)) begin
          tx_pop = 1'b1;
          st_next.tx_sh = txw & mask;
          st_next.tx_par = par_f(txw & mask, l);
          st_next.tx_st = TX_START;
        end
      end
      TX_START: begin
        if (tx_bend) begin
          st_next.tx_sub = 5'h00;
          st_next.tx_st = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_bend) begin
          st_next.tx_sub = 5'h00;
          st_next.tx_sh = st_reg.tx_sh >> 1;
          st_next.tx_cnt = st_reg.tx_cnt + 8'h01;
          if (st_reg.tx_cnt == {4'h0, nb} - 8'h01) begin
            st_next.tx_st = l[`ASP_L_PEN] ? TX_PAR : TX_STOP;
          end
        end
      end
      TX_PAR: begin
        if (tx_bend) begin
          st_next.tx_sub = 5'h00;
          st_next.tx_st = TX_STOP;
        end
      end
      TX_STOP: begin
        if (tick && st_reg.tx_sub == stop_last) begin
          st_next.tx_sub = 5'h00;
          st_next.tx_cnt = 8'h00;
          st_next.tx_st = st_reg.tog[`ASP_T_GAP] != 8'h00 ? TX_GAP : TX_IDLE;
        end
      end
      TX_GAP: begin
        if (tx_bend) begin
          st_next.tx_sub = 5'h00;
          st_next.tx_cnt = st_reg.tx_cnt + 8'h01;
          if (st_reg.tx_cnt == st_reg.tog[`ASP_T_GAP] - 8'h01) begin
            st_next.tx_st = TX_IDLE;
          end
        end
      end
      TX_BRK: begin
        if (tx_bend) begin
          st_next.tx_sub = 5'h00;
          st_next.tx_cnt = st_reg.tx_cnt + 8'h01;
          if (st_reg.tx_cnt == {3'h0, st_reg.tog[`ASP_T_BRK]} - 8'h01) begin
            st_next.tx_st = TX_STOP;
          end
        end
      end
      default: st_next.tx_st = TX_IDLE;
    endcase
    if (tx_pop) begin
      st_next.tx_rp = st_reg.tx_rp + 4'h1;
    end
    st_next.tx_n = st_reg.tx_n + {4'h0, tx_push} - {4'h0, tx_pop};
    // line output, sir pulse in first 3/16 of a zero bit
    if (l[`ASP_L_IRDA]) begin
      st_next.txd = !tx_bit && st_reg.tx_sub < `ASP_IR_PULSE;
    end else begin
      st_next.txd = tx_bit;
    end
    // sir pulse stretcher
    if (rxd_in) begin
      st_next.ir_cnt = `ASP_OVS_LAST;
    end else if (tick && st_reg.ir_cnt != 4'h0) begin
      st_next.ir_cnt = st_reg.ir_cnt - 4'h1;
    end
    // receive timeout counter in bit times
    if (st_reg.rx_n == 5'h00 || rx_pop) begin
      st_next.to_sub = 4'h0;
      st_next.to_cnt = 8'h00;
    end else if (tick) begin
      st_next.to_sub = st_reg.to_sub + 4'h1;
      if (st_reg.to_sub == `ASP_OVS_LAST && st_reg.to_cnt != st_reg.tog[`ASP_T_TO]) begin
        st_next.to_cnt = st_reg.to_cnt + 8'h01;
      end
    end
    if (st_reg.tog[`ASP_T_TO] != 8'h00 && st_reg.to_cnt == st_reg.tog[`ASP_T_TO]) begin
      ev_set[`ASP_E_TOUT] = 1'b1;
    end
    // receiver
    if (st_reg.rx_st != RX_IDLE && tick) begin
      st_next.rx_sub = st_reg.rx_sub + 4'h1;
    end
    case (st_reg.rx_st)
      RX_IDLE: begin
        st_next.rx_sub = 4'h0;
        st_next.rx_cnt = 4'h0;
        if (tick && !rxline) begin
          st_next.rx_st = RX_START;
        end
      end
      RX_START: begin
        // half a bit later, still low or a glitch
        if (tick && st_reg.rx_sub == `ASP_MID) begin
          st_next.rx_sub = 4'h0;
          st_next.rx_st = rxline ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_bend) begin
          st_next.rx_sh = {rxline, st_reg.rx_sh[8:1]};
          st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
          if (st_reg.rx_cnt == nb - 4'h1) begin
            st_next.rx_st = l[`ASP_L_PEN] ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (rx_bend) begin
          st_next.rx_par = rxline;
          st_next.rx_st = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_bend) begin
          st_next.rx_st = RX_IDLE;
          st_next.to_sub = 4'h0;
          st_next.to_cnt = 8'h00;
          ev_set[`ASP_E_FERR] = !rxline;
          ev_set[`ASP_E_BRK] = !rxline && rxw == 9'h000 &&
            (!l[`ASP_L_PEN] || !st_reg.rx_par);
          ev_set[`ASP_E_PERR] = l[`ASP_L_PEN] && st_reg.rx_par != par_f(rxw, l);
          if (st_reg.rx_n == `ASP_DEPTH) begin
            ev_set[`ASP_E_ROVF] = 1'b1;
          end else begin
            rx_push = 1'b1;
          end
        end
      end
      default: st_next.rx_st = RX_IDLE;
    endcase
    // receive queue
    if (rx_push) begin
      st_next.rxq[st_reg.rx_wp] = rxw;
      st_next.rx_wp = st_reg.rx_wp + 4'h1;
    end
    if (rx_pop) begin
      st_next.rx_rp = st_reg.rx_rp + 4'h1;
    end
    st_next.rx_n = st_reg.rx_n + {4'h0, rx_push} - {4'h0, rx_pop};
    // lin break: eleven low bit times
    if (l[`ASP_L_LIN] && !rxline) begin
      if (tick && st_reg.low_run != `ASP_LBRK) begin
        st_next.low_run = st_reg.low_run + 8'h01;
      end
      if (tick && st_reg.low_run == `ASP_LBRK - 8'h01) begin
        ev_set[`ASP_E_LINB] = 1'b1;
      end
    end else begin
      st_next.low_run = 8'h00;
    end
    // data ready at threshold, transmit queue empty
    if (st_reg.rx_n != 5'h00 && st_reg.rx_n >= {1'b0, st_reg.fcr[`ASP_F_RXT]}) begin
      ev_set[`ASP_E_RXT] = 1'b1;
    end
    ev_set[`ASP_E_TXE] = st_reg.tx_n == 5'h00;
    // cts change detect and wake pulse
    st_next.cts_q = cts_in;
    st_next.wake = cts_in != st_reg.cts_q;
    ev_set[`ASP_E_CTSC] = cts_in != st_reg.cts_q;
    // summary sources
    ev_set[`ASP_E_LERR] = ev_set[`ASP_E_BRK] | ev_set[`ASP_E_FERR] | ev_set[`ASP_E_PERR];
    ev_set[`ASP_E_BOVF] = ev_set[`ASP_E_ROVF] | ev_set[`ASP_E_TOVF];
    // sticky flags, a set beats a clear
    st_next.ev = (st_reg.ev & ~ev_clr) | ev_set;
    // rts: rs-485 direction or flow control
    if (l[`ASP_L_485]) begin
      st_next.rts = l[`ASP_L_485A] ? tx_busy : l[`ASP_L_RTSL];
    end else if (l[`ASP_L_ARTS]) begin
      st_next.rts = st_reg.rx_n >= {1'b0, st_reg.fcr[`ASP_F_RTST]};
    end else begin
      st_next.rts = l[`ASP_L_RTSL];
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      st_reg <= '0;
      st_reg.lcr <= `ASP_LINE_RST;
      st_reg.fcr <= `ASP_FIFO_RST;
      st_reg.div <= `ASP_DIV_RST;
      st_reg.tog <= `ASP_TOG_RST;
      st_reg.txd <= 1'b1;
      st_reg.cts_q <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign rd_data_out = st_reg.rdata;
  assign txd_out = st_reg.txd;
  assign rts_out = st_reg.rts;
  assign wake_out = st_reg.wake;

  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  rxq_bound_a: assert property (st_reg.rx_n <= `ASP_DEPTH)
    else $error("receive queue count above depth");
  tx_ovf_a: assert property ((wr_in && addr_in == `ASP_A_DATA &&
    st_reg.tx_n == `ASP_DEPTH && !tx_pop)
    |=> st_reg.ev[`ASP_E_TOVF] && st_reg.tx_n == `ASP_DEPTH)
    else $error("transmit overflow not flagged");
  start_low_a: assert property ((st_reg.tx_st == TX_START && !l[`ASP_L_IRDA])
    |=> !txd_out)
    else $error("start bit not low");
  gap_high_a: assert property ((st_reg.tx_st == TX_GAP && !l[`ASP_L_IRDA])
    |=> txd_out)
    else $error("line not idle during gap");
  rts_auto_a: assert property ((!l[`ASP_L_485] && l[`ASP_L_ARTS] &&
    st_reg.rx_n >= {1'b0, st_reg.fcr[`ASP_F_RTST]}) |=> rts_out)
    else $error("rts not raised at trigger level");
  rx_thresh_a: assert property ((st_reg.rx_n != 5'h00 &&
    st_reg.rx_n >= {1'b0, st_reg.fcr[`ASP_F_RXT]}) |=> st_reg.ev[`ASP_E_RXT])
    else $error("threshold flag missing");
  cts_wake_a: assert property ((cts_in != st_reg.cts_q) |=> wake_out ##1 !wake_out
    || $past(cts_in) != cts_in)
    else $error("wake pulse wrong");
  timeout_src_a: assert property ($rose(st_reg.ev[`ASP_E_TOUT]) |->
    $past(st_reg.rx_n) != 5'h00)
    else $error("timeout flagged with empty queue");
  sir_pulse_a: assert property (($past(l[`ASP_L_IRDA]) && txd_out) |->
    $past(st_reg.tx_st) != TX_IDLE)
    else $error("sir pulse while idle");
  baud_read_a: assert property ((rd_in && addr_in == `ASP_A_BAUD) |=>
    rd_data_out == {16'h0000, $past(st_reg.div)} ##1 rd_data_out == 32'h0000_0000
    || $past(rd_in))
    else $error("divisor readback wrong");

  frame_done_c: cover property (st_reg.tx_st == TX_STOP ##1 st_reg.tx_st == TX_IDLE);
  rx_push_c: cover property (st_reg.rx_st == RX_STOP ##1 st_reg.rx_n != 5'h00);
  lin_brk_c: cover property ($rose(st_reg.ev[`ASP_E_LINB]));
  timeout_c: cover property ($rose(st_reg.ev[`ASP_E_TOUT]));
endmodule : asp_core

// ---- verilog/asp_defines.svh ----
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH
// register byte offsets
`define ASP_A_DATA 8'h00
`define ASP_A_LINE 8'h04
`define ASP_A_FIFO 8'h08
`define ASP_A_BAUD 8'h0C
`define ASP_A_TOG 8'h10
`define ASP_A_STAT 8'h14
`define ASP_A_EVT 8'h18
// line control fields
`define ASP_L_WLEN 1:0
`define ASP_L_STOP2 2
`define ASP_L_PEN 3
`define ASP_L_EVEN 4
`define ASP_L_STICK 5
`define ASP_L_NINE 6
`define ASP_L_IRDA 7
`define ASP_L_LIN 8
`define ASP_L_LMST 9
`define ASP_L_ARTS 10
`define ASP_L_ACTS 11
`define ASP_L_485 12
`define ASP_L_485A 13
`define ASP_L_RTSL 14
`define ASP_L_BRK 15
`define ASP_L_STORE 14:0
// fifo control, timeout/gap, word fields
`define ASP_F_RXT 3:0
`define ASP_F_RTST 7:4
`define ASP_F_STORE 7:0
`define ASP_B_STORE 15:0
`define ASP_T_TO 7:0
`define ASP_T_GAP 15:8
`define ASP_T_BRK 20:16
`define ASP_T_STORE 20:0
`define ASP_WORD 8:0
// event flag bits
`define ASP_E_RXT 0
`define ASP_E_TXE 1
`define ASP_E_LERR 2
`define ASP_E_CTSC 3
`define ASP_E_TOUT 4
`define ASP_E_BOVF 5
`define ASP_E_LINB 6
`define ASP_E_BRK 8
`define ASP_E_FERR 9
`define ASP_E_PERR 10
`define ASP_E_ROVF 11
`define ASP_E_TOVF 12
`define ASP_EV_STORE 12:0
// reset values
`define ASP_LINE_RST 15'h0003
`define ASP_FIFO_RST 8'hE1
`define ASP_DIV_RST 16'h0001
`define ASP_TOG_RST 21'h0D_0000
// queue depth, word lengths and timing counts in oversample ticks
`define ASP_DEPTH 5'h10
`define ASP_BIT_LAST 5'h0F
`define ASP_STOP15 5'h17
`define ASP_STOP2 5'h1F
`define ASP_MID 4'h7
`define ASP_OVS_LAST 4'hF
`define ASP_IR_PULSE 5'h03
`define ASP_LBRK 8'hB0
`define ASP_NB_MIN 4'h5
`define ASP_NB_NINE 4'h9
`endif

// ---- verilog/asp_pkg.sv ----
package asp_pkg;
  // transmitter states
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
    TX_PAR = 3'b011, TX_STOP = 3'b100, TX_GAP = 3'b101, TX_BRK = 3'b110
  } asp_tx_e;
  // receiver states
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
    RX_PAR = 3'b011, RX_STOP = 3'b100
  } asp_rx_e;
  // whole block state
  typedef struct packed {
    logic [14:0] lcr;
    logic [7:0] fcr;
    logic [15:0] div;
    logic [20:0] tog;
    logic [12:0] ev;
    logic brk_req;
    logic [15:0] bcnt;
    asp_tx_e tx_st;
    logic [8:0] tx_sh;
    logic tx_par;
    logic [7:0] tx_cnt;
    logic [4:0] tx_sub;
    logic [15:0][8:0] txq;
    logic [3:0] tx_wp;
    logic [3:0] tx_rp;
    logic [4:0] tx_n;
    asp_rx_e rx_st;
    logic [8:0] rx_sh;
    logic rx_par;
    logic [3:0] rx_cnt;
    logic [3:0] rx_sub;
    logic [15:0][8:0] rxq;
    logic [3:0] rx_wp;
    logic [3:0] rx_rp;
    logic [4:0] rx_n;
    logic [3:0] to_sub;
    logic [7:0] to_cnt;
    logic [7:0] low_run;
    logic [3:0] ir_cnt;
    logic cts_q;
    logic txd;
    logic rts;
    logic wake;
    logic [31:0] rdata;
  } asp_state_s;
endpackage : asp_pkg

// ---- testbench/asp_peer.sv ----
`timescale 1ns/1ps
module asp_peer #(
  parameter int BIT = 16 // clocks per bit
) (
  input wire logic clk_in, // bench clock
  input wire logic txd_in, // line from the block
  input wire logic echo_in, // loop line back
  input wire logic hold_in, // peer not ready
  output logic rxd_out, // line into the block
  output logic cts_n_out, // clear to send, low ready
  output logic [7:0] word_out, // last decoded word
  output logic got_out // pulse, stop seen high
);
  int cnt = 0; // clocks to next sample
  int nb = 0; // bits taken so far
  logic busy = 1'b0; // inside a frame
  // echo the line, else the pull-up holds it idle high
  assign rxd_out = echo_in ? txd_in : 1'b1;
  // slow peer holds the block off
  assign cts_n_out = hold_in;
  // centre sampling decoder for 8-bit frames
  always @(posedge clk_in) begin
    got_out <= 1'b0;
    if (!busy) begin
      if (txd_in == 1'b0) begin
        busy <= 1'b1;
        cnt <= BIT + BIT / 2 - 1;
        nb <= 0;
      end
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end else if (nb < 8) begin
      word_out <= {txd_in, word_out[7:1]};
      nb <= nb + 1;
      cnt <= BIT - 1;
    end else begin
      busy <= 1'b0;
      got_out <= txd_in;
    end
  end
endmodule : asp_peer

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`include "asp_defines.svh"
module tb_top;
  logic clk_in = 1'b0; // bench clock
  logic rstn_in = 1'b0; // reset, low
  logic [7:0] addr_in = 8'h00; // register address
  logic [31:0] wr_data_in = 32'h0000_0000; // write data
  logic wr_in = 1'b0; // write strobe
  logic rd_in = 1'b0; // read strobe
  logic [31:0] rd_data_out, r; // read data, last read
  logic rxd, cts_n, txd_out, rts_out, wake_out, got; // line side
  logic echo = 1'b1; // peer loops the line
  logic hold = 1'b0; // peer holds clear to send
  logic [7:0] pword; // peer decoded word
  int num_errors = 0;
  int n_checks = 0;
  // 200 MHz clock
  always #2.5 clk_in = ~clk_in;
  asp_core uut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
    .rxd_in(rxd), .cts_in(cts_n), .txd_out(txd_out), .rts_out(rts_out),
    .wake_out(wake_out));
  asp_peer #(.BIT(16)) peer (.clk_in(clk_in), .txd_in(txd_out), .echo_in(echo),
    .hold_in(hold), .rxd_out(rxd), .cts_n_out(cts_n), .word_out(pword), .got_out(got));
  // compare one value
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // step n edges, settle after the last
  task tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  // one write cycle
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  // one read cycle, data taken the cycle after
  task rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    r = rd_data_out;
    chk(r & m, e);
  endtask : rdm
  // count consecutive low samples of the line
  task lowrun(output int n);
    for (n = 0; txd_out === 1'b0 && n < 400; n++) tick(1);
  endtask : lowrun
  // reset values, unmapped place, bit period
  task t_regs;
    int n;
    rdm(`ASP_A_LINE, 32'hFFFF_FFFF, 32'h0000_0003);
    rdm(`ASP_A_FIFO, 32'hFFFF_FFFF, 32'h0000_00E1);
    rdm(`ASP_A_BAUD, 32'hFFFF_FFFF, 32'h0000_0001);
    rdm(`ASP_A_TOG, 32'hFFFF_FFFF, 32'h000D_0000);
    wr(8'h1C, 32'hFFFF_FFFF);
    rdm(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
    echo = 1'b0;
    wr(`ASP_A_DATA, 32'h0000_0001);
    tick(1);
    chk(32'(txd_out), 32'h0000_0001);
    tick(1);
    lowrun(n);
    chk(32'(n), 32'h0000_0020);
    tick(400);
    echo = 1'b1;
    wr(`ASP_A_BAUD, 32'h0000_0000);
  endtask : t_regs
  // loop one frame, threshold and timeout flags
  task t_frame;
    int n;
    wr(`ASP_A_TOG, 32'h000D_0002);
    wr(`ASP_A_DATA, 32'h0000_00A5);
    for (int i = 0; i < 400 && got !== 1'b1; i++) tick(1);
    chk(32'(got), 32'h0000_0001);
    chk(32'(pword), 32'h0000_00A5);
    tick(20);
    rdm(`ASP_A_EVT, 32'h0000_0011, 32'h0000_0001);
    tick(60);
    rdm(`ASP_A_EVT, 32'h0000_0010, 32'h0000_0010);
    rdm(`ASP_A_DATA, 32'h0000_01FF, 32'h0000_00A5);
    rdm(`ASP_A_STAT, 32'h0000_001F, 32'h0000_0000);
    wr(`ASP_A_TOG, 32'h000D_0200);
    wr(`ASP_A_DATA, 32'h0000_0000);
    wr(`ASP_A_DATA, 32'h0000_0000);
    tick(1);
    for (int i = 0; i < 400 && txd_out !== 1'b1; i++) tick(1);
    // stop, two gap bit times, one idle cycle before the next start
    for (n = 0; txd_out === 1'b1 && n < 400; n++) tick(1);
    chk(32'(n), 32'h0000_0031);
    tick(300);
    rdm(`ASP_A_DATA, 32'h0000_01FF, 32'h0000_0000);
    rdm(`ASP_A_DATA, 32'h0000_01FF, 32'h0000_0000);
    wr(`ASP_A_TOG, 32'h000D_0000);
    wr(`ASP_A_EVT, 32'h0000_1FFF);
  endtask : t_frame
  // every length, parity kind and stop count
  task t_modes;
    logic [7:0] v;
    logic p;
    for (int wl = 0; wl < 4; wl++) begin
      for (int m = 0; m < 5; m++) begin
        v = 8'hC9 & (8'hFF >> (3 - wl));
        p = (m == 1) ? ~^v : (m == 2) ? ^v : (m == 3);
        // m: none, odd, even, stick one, stick zero; odd m adds the long stop
        wr(`ASP_A_LINE, 32'(wl) |
          {26'h000_0000, m >= 3, m == 2 || m == 4, m != 0, m % 2 == 1, 2'h0});
        wr(`ASP_A_DATA, 32'(v));
        if (m != 0) begin
          tick(26 + 16 * (wl + 5));
          chk(32'(txd_out), 32'(p));
        end
        tick(300);
        rdm(`ASP_A_DATA, 32'h0000_01FF, 32'(v));
        rdm(`ASP_A_EVT, 32'h0000_0700, 32'h0000_0000);
      end
    end
    wr(`ASP_A_LINE, 32'h0000_0003);
  endtask : t_modes
  // queue fill, overflow, cts hold and wake, rts level
  task t_flow;
    int n;
    wr(`ASP_A_LINE, 32'h0000_0C03);
    @(posedge clk_in);
    hold <= 1'b1;
    n = 0;
    repeat (6) begin
      tick(1);
      if (wake_out !== 1'b0) n++;
    end
    chk(32'(n), 32'h0000_0001);
    for (int i = 0; i < 17; i++) wr(`ASP_A_DATA, 32'(i));
    rdm(`ASP_A_STAT, 32'h0000_03E0, 32'h0000_0200);
    rdm(`ASP_A_EVT, 32'h0000_1020, 32'h0000_1020);
    tick(50);
    chk(32'(txd_out), 32'h0000_0001);
    wr(`ASP_A_EVT, 32'h0000_1FFF);
    @(posedge clk_in);
    hold <= 1'b0;
    tick(3000);
    rdm(`ASP_A_STAT, 32'h0000_001F, 32'h0000_0010);
    chk(32'(rts_out), 32'h0000_0001);
    for (int i = 0; i < 16; i++) rdm(`ASP_A_DATA, 32'h0000_01FF, 32'(i));
    tick(2);
    chk(32'(rts_out), 32'h0000_0000);
    rdm(`ASP_A_EVT, 32'h0000_0800, 32'h0000_0000);
  endtask : t_flow
  // infrared pulses, then break send and detect
  task t_sir_lin;
    int n;
    wr(`ASP_A_LINE, 32'h0000_0083);
    wr(`ASP_A_DATA, 32'h0000_0000);
    n = 0;
    repeat (250) begin
      tick(1);
      if (txd_out !== 1'b0) n++;
    end
    chk(32'(n), 32'h0000_001B);
    rdm(`ASP_A_STAT, 32'h0000_001F, 32'h0000_0001);
    rdm(`ASP_A_DATA, 32'h0000_01FF, 32'h0000_0000);
    wr(`ASP_A_LINE, 32'h0000_0303);
    tick(40);
    // a slave asked for a break keeps the line idle
    wr(`ASP_A_LINE, 32'h0000_8103);
    tick(40);
    chk(32'(txd_out), 32'h0000_0001);
    wr(`ASP_A_EVT, 32'h0000_1FFF);
    wr(`ASP_A_LINE, 32'h0000_8303);
    for (int i = 0; i < 20 && txd_out !== 1'b0; i++) tick(1);
    lowrun(n);
    chk(32'(n), 32'h0000_00D0);
    // let the second frame seen inside the long low land in the queue
    tick(200);
    rdm(`ASP_A_EVT, 32'h0000_0040, 32'h0000_0040);
    rdm(`ASP_A_EVT, 32'h0000_0704, 32'h0000_0304);
    rdm(`ASP_A_DATA, 32'h0000_0000, 32'h0000_0000);
    rdm(`ASP_A_DATA, 32'h0000_0000, 32'h0000_0000);
  endtask : t_sir_lin
  // nine-bit words and direction control
  task t_485;
    wr(`ASP_A_LINE, 32'h0000_3043);
    wr(`ASP_A_DATA, 32'h0000_01A5);
    tick(40);
    chk(32'(rts_out), 32'h0000_0001);
    tick(300);
    chk(32'(rts_out), 32'h0000_0000);
    rdm(`ASP_A_DATA, 32'h0000_01FF, 32'h0000_01A5);
    wr(`ASP_A_LINE, 32'h0000_5043);
    tick(2);
    chk(32'(rts_out), 32'h0000_0001);
  endtask : t_485
  // counts, verdict, end of run
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  // main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_regs;
    t_frame;
    t_modes;
    t_flow;
    t_sir_lin;
    t_485;
    print_verdict;
  end
  // hang guard, well past the expected run
  initial begin
    repeat (40000) @(posedge clk_in);
    num_errors++;
    print_verdict;
  end
endmodule : tb_top
